// ===== srd_strap_sampler.sv
// strap decode package and the four-level strap sampler
`timescale 1ns/1ps
`default_nettype none

package srd_pkg;

	// ---------------------------------------------------------------
	// strap level coding
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SRD_LOW,
		SRD_RES_LOW,
		SRD_FLOAT,
		SRD_HIGH
	} srd_level_type;

	// pin voltage sampled as a fraction of the supply rail, full scale = rail
	localparam int          CODE_W        = 8;
	localparam int          FULL_SCALE    = 255;
	// thresholds in tenths of the rail
	localparam int          THR_LR_TENTHS = 2;
	localparam int          THR_RF_TENTHS = 5;
	localparam int          THR_FH_TENTHS = 8;
	localparam logic [7:0]  THR_LR        = 8'((FULL_SCALE * THR_LR_TENTHS) / 10);
	localparam logic [7:0]  THR_RF        = 8'((FULL_SCALE * THR_RF_TENTHS) / 10);
	localparam logic [7:0]  THR_FH        = 8'((FULL_SCALE * THR_FH_TENTHS) / 10);
	// open pin bias point, two thirds of the rail
	localparam logic [7:0]  OPEN_PIN_CODE = 8'((FULL_SCALE * 2) / 3);

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int          CLK_PERIOD_PS    = 8000;
	localparam int          SETTLE_NS        = 1000;
	localparam int          SETTLE_CYCLES    = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          SETTLE_W         = 8;
	localparam int          MGMT_READY_MS    = 50;
	localparam longint      MGMT_READY_CYCLES_L =
		(longint'(MGMT_READY_MS) * 64'd1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          MGMT_READY_CYCLES = int'(MGMT_READY_CYCLES_L);
	localparam int          MGMT_CNT_W        = 23;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic primary;
		logic secondary;
		logic secondary_en;
		logic loopback;
		logic loopback_en;
	} srd_route_type;

	// classify a sampled pin code into one of four levels
	function automatic srd_level_type classify(input logic [7:0] code);
		srd_level_type lvl;
		lvl = SRD_HIGH;
		if (code < THR_LR) begin
			lvl = SRD_LOW;
		end else if (code < THR_RF) begin
			lvl = SRD_RES_LOW;
		end else if (code < THR_FH) begin
			lvl = SRD_FLOAT;
		end
		return lvl;
	endfunction

	// a route select opens its output when strapped low (hard or resistor)
	function automatic logic route_open(input srd_level_type lvl);
		return (lvl == SRD_LOW) || (lvl == SRD_RES_LOW);
	endfunction

endpackage

module srd_strap_sampler (
	// clock, reset, enable
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	// sampled pin level, asynchronous to the clock
	input  wire logic [7:0]            level_code_i,
	// decoded level
	output srd_pkg::srd_level_type     level_o
);

	logic [7:0]             code_s1;
	logic [7:0]             code_s2;
	srd_pkg::srd_level_type level;

	// two-stage synchroniser; the strap is static so bit skew only lasts a sample
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			code_s1 <= srd_pkg::OPEN_PIN_CODE;
			code_s2 <= srd_pkg::OPEN_PIN_CODE;
		end else if (ce_i) begin
			code_s1 <= level_code_i;
			code_s2 <= code_s1;
		end
	end

	// classify into four levels, reset to the open-pin default
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			level <= srd_pkg::SRD_FLOAT;
		end else if (ce_i) begin
			level <= srd_pkg::classify(code_s2);
		end
	end

	assign level_o = level;

	AST_STRAP_CLASSIFY: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i |=> level == srd_pkg::classify($past(code_s2)))
		else $error("strap level does not match its sampled code");

	AST_OPEN_PIN_FLOAT: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && code_s2 == srd_pkg::OPEN_PIN_CODE) |=> level == srd_pkg::SRD_FLOAT)
		else $error("open pin bias point not decoded as float");

endmodule

`default_nettype wire

// ===== srd_route_top.sv
// strap decode and output route selection for the reclocked host stream
`timescale 1ns/1ps
`default_nettype none

module srd_route_top #(
	parameter int MGMT_READY_CYCLES = srd_pkg::MGMT_READY_CYCLES,
	parameter int SETTLE_CYCLES     = srd_pkg::SETTLE_CYCLES
) (
	// clock, reset, enable
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	// equalized host serial stream, from the pin side
	input  wire logic                  host_serial_input_i,
	// strap pin levels as fractions of the supply rail
	input  wire logic [7:0]            loopback_route_select_i,
	input  wire logic [7:0]            secondary_route_select_i,
	// line-side and host-side drivers
	output logic                       primary_line_output_o,
	output logic                       secondary_line_output_o,
	output logic                       secondary_line_enable_o,
	output logic                       host_loopback_output_o,
	output logic                       host_loopback_enable_o,
	// status
	output srd_pkg::srd_level_type     loopback_route_state_o,
	output srd_pkg::srd_level_type     secondary_route_state_o,
	output logic                       straps_locked_o,
	output logic                       mgmt_port_ready_o
);

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	// refuse counts that the counters cannot hold
	if (MGMT_READY_CYCLES < 1 || MGMT_READY_CYCLES >= (1 << srd_pkg::MGMT_CNT_W)) begin
		$error("MGMT_READY_CYCLES out of counter range");
	end
	if (SETTLE_CYCLES < 4 || SETTLE_CYCLES >= (1 << srd_pkg::SETTLE_W)) begin
		$error("SETTLE_CYCLES must cover the sampler latency and fit its counter");
	end

	typedef enum logic {
		SRD_SETTLE,
		SRD_LOCKED
	} srd_lock_state_type;

	srd_lock_state_type                   lock_state;
	logic [srd_pkg::SETTLE_W-1:0]         settle_cnt;
	logic [srd_pkg::MGMT_CNT_W-1:0]       ready_cnt;
	logic                                 mgmt_ready;
	logic                                 straps_locked;
	logic                                 data_s1;
	logic                                 data_s2;
	srd_pkg::srd_level_type               lb_live;
	srd_pkg::srd_level_type               sec_live;
	srd_pkg::srd_level_type               lb_held;
	srd_pkg::srd_level_type               sec_held;
	srd_pkg::srd_route_type               route;

	// ---------------------------------------------------------------
	// strap sampling
	// ---------------------------------------------------------------
	srd_strap_sampler u_lb_strap (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.level_code_i (loopback_route_select_i),
		.level_o      (lb_live)
	);

	srd_strap_sampler u_sec_strap (
		.ref_clk_i    (ref_clk_i),
		.rst_i        (rst_i),
		.ce_i         (ce_i),
		.level_code_i (secondary_route_select_i),
		.level_o      (sec_live)
	);

	// wait for the synchronised straps to settle, then freeze them
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_state <= SRD_SETTLE;
			settle_cnt <= '0;
			straps_locked <= 1'b0;
			lb_held    <= srd_pkg::SRD_FLOAT;
			sec_held   <= srd_pkg::SRD_FLOAT;
		end else if (ce_i) begin
			case (lock_state)
				SRD_SETTLE: begin
					if (settle_cnt == srd_pkg::SETTLE_W'(SETTLE_CYCLES - 1)) begin
						lb_held    <= lb_live;
						sec_held   <= sec_live;
						lock_state <= SRD_LOCKED;
						straps_locked <= 1'b1; // status flag from its own flop
					end else begin
						settle_cnt <= settle_cnt + 1'b1;
					end
				end
				SRD_LOCKED: begin
					lock_state <= SRD_LOCKED; // held until the next reset
				end
				default: begin
					lock_state <= SRD_SETTLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// management port readiness after power-on
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ready_cnt  <= '0;
			mgmt_ready <= 1'b0;
		end else if (ce_i && !mgmt_ready) begin
			if (ready_cnt == srd_pkg::MGMT_CNT_W'(MGMT_READY_CYCLES - 1)) begin
				mgmt_ready <= 1'b1;
			end else begin
				ready_cnt <= ready_cnt + 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// data path
	// ---------------------------------------------------------------
	// reclock the host stream onto the device clock
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_s1 <= 1'b0;
			data_s2 <= 1'b0;
		end else if (ce_i) begin
			data_s1 <= host_serial_input_i;
			data_s2 <= data_s1;
		end
	end

	// route the reclocked stream to the drivers chosen by the held straps
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			route <= '0;
		end else if (ce_i) begin
			route.primary      <= data_s2;
			route.secondary_en <= (lock_state == SRD_LOCKED) && srd_pkg::route_open(sec_held);
			route.secondary    <= (lock_state == SRD_LOCKED) && srd_pkg::route_open(sec_held)
				&& data_s2;
			route.loopback_en  <= (lock_state == SRD_LOCKED) && srd_pkg::route_open(lb_held);
			route.loopback     <= (lock_state == SRD_LOCKED) && srd_pkg::route_open(lb_held)
				&& data_s2;
		end
	end

	// outputs straight from flip-flops
	assign primary_line_output_o   = route.primary;
	assign secondary_line_output_o = route.secondary;
	assign secondary_line_enable_o = route.secondary_en;
	assign host_loopback_output_o  = route.loopback;
	assign host_loopback_enable_o  = route.loopback_en;
	assign loopback_route_state_o  = lb_held;
	assign secondary_route_state_o = sec_held;
	assign straps_locked_o         = straps_locked;
	assign mgmt_port_ready_o       = mgmt_ready;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_PRIMARY_ALWAYS: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		ce_i ##1 ce_i ##1 ce_i |=> route.primary == $past(host_serial_input_i, 3))
		else $error("primary output does not follow the host input");

	AST_LOOPBACK_SAME_DATA: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		route.loopback_en |-> route.loopback == route.primary)
		else $error("loop-back data differs from primary line data");

	AST_SECONDARY_ROUTE: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && lock_state == SRD_LOCKED) |=>
			route.secondary_en == srd_pkg::route_open(sec_held)
			&& route.secondary == (route.secondary_en && route.primary))
		else $error("secondary output route wrong for its strap");

	AST_LOOPBACK_ROUTE: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		(ce_i && lock_state == SRD_LOCKED && lb_held == srd_pkg::SRD_HIGH) |=>
			!route.loopback_en && !route.loopback)
		else $error("loop-back enabled while its strap is high");

	AST_NO_ROUTE_BEFORE_LOCK: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		lock_state == SRD_SETTLE |=> !route.secondary_en && !route.loopback_en)
		else $error("route enabled before straps were held");

	AST_STRAPS_HELD: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		lock_state == SRD_LOCKED |=> lock_state == SRD_LOCKED
			&& $stable(lb_held) && $stable(sec_held))
		else $error("held strap state changed after lock");

	AST_MGMT_NOT_EARLY: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		mgmt_ready |-> ready_cnt == srd_pkg::MGMT_CNT_W'(MGMT_READY_CYCLES - 1))
		else $error("management ready raised before the power-on wait");

endmodule

`default_nettype wire

// ===== srd_board_model.sv
// board strap resistors and host serial source feeding the route block
`timescale 1ns/1ps
`default_nettype none

module srd_board_model (
	// clock
	input  wire logic       ref_clk_i,
	// strap settings chosen by the bench
	input  wire logic [7:0] lb_code_i,
	input  wire logic [7:0] sec_code_i,
	input  wire logic       lb_open_i,
	input  wire logic       sec_open_i,
	// pins seen by the block
	output logic [7:0]      lb_pin_o,
	output logic [7:0]      sec_pin_o,
	output logic            serial_o
);
	// an open pin rests on the internal bias divider at two thirds of rail
	localparam logic [7:0] OPEN_CODE = 8'hAA;
	logic [6:0] lfsr = 7'h5A;

	// strap divider: external resistor, or internal bias only when open
	assign lb_pin_o  = lb_open_i ? OPEN_CODE : lb_code_i;
	assign sec_pin_o = sec_open_i ? OPEN_CODE : sec_code_i;

	// reclocked stream source, pattern changes every cycle
	always begin
		@(posedge ref_clk_i);
		#1;
		lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
	end
	assign serial_o = lfsr[0];
endmodule

`default_nettype wire

// ===== strap_decode_route_select_tb_top.sv
// self-checking bench for strap decode and output routing
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, a, e); end end

module strap_decode_route_select_tb_top;
	localparam int SETTLE = 8;
	localparam int MGMT   = 20;
	int fail_count = 0;
	int tests_run  = 0;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] lb_code = 8'h00;
	logic [7:0] sec_code = 8'h00;
	logic lb_open = 1'b1;
	logic sec_open = 1'b1;
	logic [2:0] hist = 3'h0;
	logic ce = 1'b1;
	wire logic [7:0] lb_pin, sec_pin;
	wire logic serial;
	logic prim, sec, sec_en, lb, lb_en, locked, ready;
	srd_pkg::srd_level_type lb_st, sec_st;

	srd_board_model i_srd_board_model (.ref_clk_i(ref_clk_i), .lb_code_i(lb_code),
		.sec_code_i(sec_code), .lb_open_i(lb_open), .sec_open_i(sec_open),
		.lb_pin_o(lb_pin), .sec_pin_o(sec_pin), .serial_o(serial));
	srd_route_top #(.MGMT_READY_CYCLES(MGMT), .SETTLE_CYCLES(SETTLE)) i_srd_route_top (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .host_serial_input_i(serial),
		.loopback_route_select_i(lb_pin), .secondary_route_select_i(sec_pin),
		.primary_line_output_o(prim), .secondary_line_output_o(sec),
		.secondary_line_enable_o(sec_en), .host_loopback_output_o(lb),
		.host_loopback_enable_o(lb_en), .loopback_route_state_o(lb_st),
		.secondary_route_state_o(sec_st), .straps_locked_o(locked),
		.mgmt_port_ready_o(ready));

	// 125 MHz clock and stream history seen at the block input
	always #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) hist <= {hist[1:0], serial};

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// reset with given straps, then wait for the lock under a bound
	task automatic start(input logic [7:0] lc, input logic [7:0] sc, input logic lo,
			input logic so);
		int n;
		lb_code = lc;
		sec_code = sc;
		lb_open = lo;
		sec_open = so;
		rst_i = 1'b1;
		step(2);
		rst_i = 1'b0;
		n = 0;
		while (locked !== 1'b1 && n < 300) begin
			`CHK({sec_en, lb_en}, 2'b00)
			step(1);
			n++;
		end
		if (n >= 300) begin
			fail_count++;
			final_report();
		end
		`CHK(n == SETTLE || n == SETTLE + 1, 1'b1)
		step(2);
	endtask

	// decoded states, enables and three-cycle data path on every output
	task automatic check_routes(input int el, input int es);
		logic lo, so;
		lo = (el < 2);
		so = (es < 2);
		`CHK(lb_st, srd_pkg::srd_level_type'(el))
		`CHK(sec_st, srd_pkg::srd_level_type'(es))
		repeat (12) begin
			step(1);
			`CHK(prim, hist[2])
			`CHK({sec_en, sec}, {so, so & hist[2]})
			`CHK({lb_en, lb}, {lo, lo & hist[2]})
		end
	endtask

	// threshold boundaries, each code on the loop-back select paired with the mirrored code on the secondary select
	task automatic test_levels();
		logic [7:0] code [8] = '{8'h00, 8'h32, 8'h33, 8'h7E, 8'h7F, 8'hCB, 8'hCC, 8'hFF};
		int lvl [8] = '{0, 0, 1, 1, 2, 2, 3, 3};
		for (int i = 0; i < 8; i++) begin
			start(code[i], code[7 - i], 1'b0, 1'b0);
			check_routes(lvl[i], lvl[7 - i]);
		end
		$display("test_levels done");
	endtask

	// unconnected straps decode as float and keep both extra routes shut
	task automatic test_open_pins();
		start(8'h00, 8'h00, 1'b1, 1'b1);
		check_routes(2, 2);
		$display("test_open_pins done");
	endtask

	// strap changes after lock are ignored until the next reset
	task automatic test_hold();
		start(8'hFF, 8'h00, 1'b0, 1'b0);
		lb_code = 8'h00;
		sec_code = 8'hFF;
		step(10);
		check_routes(3, 0);
		$display("test_hold done");
	endtask

	// clock enable low freezes the outputs and the settle counter
	task automatic test_freeze();
		logic [4:0] snap;
		int n;
		start(8'h00, 8'h00, 1'b0, 1'b0);
		snap = {prim, sec, sec_en, lb, lb_en};
		ce = 1'b0;
		step(6);
		`CHK({prim, sec, sec_en, lb, lb_en}, snap)
		ce = 1'b1;
		step(2);
		check_routes(0, 0);
		rst_i = 1'b1;
		ce = 1'b0;
		step(2);
		rst_i = 1'b0;
		step(10);
		`CHK(locked, 1'b0)
		ce = 1'b1;
		n = 0;
		while (locked !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		`CHK(n, SETTLE)
		$display("test_freeze done");
	endtask

	// management port reports ready only after the power-on wait
	task automatic test_mgmt();
		int n;
		rst_i = 1'b1;
		step(2);
		rst_i = 1'b0;
		n = 0;
		while (ready !== 1'b1 && n < 200) begin
			step(1);
			n++;
		end
		`CHK(n == MGMT || n == MGMT + 1, 1'b1)
		$display("test_mgmt done");
	endtask

	initial begin
		step(12);
		test_levels();
		test_open_pins();
		test_hold();
		test_freeze();
		test_mgmt();
		final_report();
	end
endmodule

`default_nettype wire
